// file: include/hyp_trap_defs.svh
// offsets, field positions, syndrome codes and reset values of the hypervisor trap block
`ifndef HYP_TRAP_DEFS_SVH
`define HYP_TRAP_DEFS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CFG_LO_OFS 8'h00
`define CFG_HI_OFS 8'h04
`define IRQ_STAT_OFS 8'h08
`define IRQ_MASK_OFS 8'h0C
`define EFF_STAT_OFS 8'h10

// ------------------------------------------------------------
// field positions in the 64-bit configuration image
// ------------------------------------------------------------
`define BIT_MISMATCH 38
`define BIT_ABORT_ROUTE 37
`define BIT_ERR_TRAP 36
`define BIT_LOR_TRAP 35
`define BIT_HOST 34
`define BIT_S2_INST_NC 33
`define BIT_S2_DATA_NC 32
`define BIT_RAO 31
`define BIT_MEMCTL_RD 30
`define BIT_HVC_DIS 29
`define BIT_TRAP_GEN 27
`define BIT_S2_EN 0

// ------------------------------------------------------------
// syndrome classes and exception levels
// ------------------------------------------------------------
`define EC_SYSREG64 6'h18
`define EC_COPROC_SINGLE 6'h03
`define EC_COPROC_DOUBLE 6'h04
`define EC_UNKNOWN 6'h00
`define EL_0 2'h0
`define EL_1 2'h1
`define EL_2 2'h2

// ------------------------------------------------------------
// interrupt status bits and reset values
// ------------------------------------------------------------
`define IRQ_ERR 0
`define IRQ_LOR 1
`define IRQ_MEMCTL 2
`define IRQ_HVC_UNDEF 3
`define IRQ_ABORT 4
`define IRQ_W 5
`define CFG_RESET 64'h0000_0000_0000_0000
`define IRQ_RESET 5'h00

`endif

// file: include/hyp_trap_pkg.sv
// types shared by the hypervisor trap block and its users
package hyp_trap_pkg;

   typedef enum logic [4:0] {
      KIND_ERR_REC = 5'h01,
      KIND_LOR_REG = 5'h02,
      KIND_MEMCTL_RD = 5'h04,
      KIND_HVC = 5'h08,
      KIND_SYNC_ABORT = 5'h10
   } kind_e;

   typedef enum logic [3:0] {
      REGIME_EL10 = 4'h1,
      REGIME_EL2 = 4'h2,
      REGIME_EL20 = 4'h4,
      REGIME_EL3 = 4'h8
   } regime_e;

   typedef struct packed {
      kind_e kind;
      logic [1:0] el;
      logic aarch32;
      logic double_reg;
      logic nonsecure;
      logic abort_to_el3;
   } chk_req_s;

   typedef struct packed {
      logic trap_el2;
      logic undef;
      logic route_el2;
      logic [1:0] target_el;
      logic [5:0] syndrome;
   } chk_resp_s;

   typedef struct packed {
      logic coherent_required;
      logic s2_inst_nc;
      logic s2_data_nc;
      logic host_at_hyp;
   } eff_s;

endpackage

// file: core/hyp_trap_route_controls.sv
// hypervisor configuration fields 38..29: storage, effective values and trap decode
//
// How it works
// - bit 38 zero keeps mismatched cacheability coherent
// - bit 38 may be read-zero, write-ignored
// - host plus trap-general ignore 38, 33, 32
// - bit 37 routes sync aborts to EL2
// - bit 36 traps AArch64 error records, 0x18
// - AArch32 error records: 0x03 single, 0x04 double
// - bit 35 traps non-secure EL1 ordering regs
// - trap-general ignores ordering and memctl traps
// - bit 34 enables host at hypervisor level
// - bit 33 forces stage 2 instruction non-cacheable
// - bit 32 forces stage 2 data non-cacheable
// - no-cache bits leave EL2, EL2&0, EL3 alone
// - bit 30 traps AArch64 memctl reads, 0x18
// - AArch32 memctl reads: 0x03 single, 0x04 double
// - no EL3, bit 29: hypervisor call undefined
// - hypervisor call at EL0 always undefined
// - warm reset leaves fields without fixed value; this block resets them to zero
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`include "hyp_trap_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module hyp_trap_route_controls
   import hyp_trap_pkg::*;
#(
   parameter bit HAS_RAS = 1'b1,
   parameter bit HAS_LOR = 1'b1,
   parameter bit HAS_VHE = 1'b1,
   parameter bit HAS_EL3 = 1'b0,
   parameter bit HAS_MISMATCH = 1'b1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // classic wishbone slave
   input wire logic cyc,
   input wire logic stb,
   input wire logic we,
   input wire logic [7:0] adr,
   input wire logic [3:0] sel,
   input wire logic [31:0] dat_w,
   output logic [31:0] dat_r,
   output logic ack,
   // execution context from the pipeline
   input wire logic el2_enabled,
   input wire regime_e regime,
   // trap check request and answer
   input wire logic chk_valid,
   input wire chk_req_s chk_req,
   output logic resp_valid,
   output chk_resp_s resp,
   // effective translation controls
   output eff_s eff,
   // interrupt
   output logic irq
);

   // ------------------------------------------------------------
   // write mask: fields of absent features stay zero
   // ------------------------------------------------------------
   localparam logic [63:0] CFG_WMASK =
      (64'(HAS_MISMATCH) << `BIT_MISMATCH) |
      (64'(HAS_RAS) << `BIT_ABORT_ROUTE) |
      (64'(HAS_RAS) << `BIT_ERR_TRAP) |
      (64'(HAS_LOR) << `BIT_LOR_TRAP) |
      (64'(HAS_VHE) << `BIT_HOST) |
      (64'h1 << `BIT_S2_INST_NC) |
      (64'h1 << `BIT_S2_DATA_NC) |
      (64'h1 << `BIT_MEMCTL_RD) |
      (64'(!HAS_EL3) << `BIT_HVC_DIS) |
      (64'h1 << `BIT_TRAP_GEN) |
      (64'h1 << `BIT_S2_EN);

   logic [63:0] cfg_r;
   logic [63:0] cfg_nxt;
   logic [`IRQ_W-1:0] stat_r;
   logic [`IRQ_W-1:0] stat_nxt;
   logic [`IRQ_W-1:0] mask_r;
   logic [`IRQ_W-1:0] mask_nxt;
   logic ack_r;
   logic [31:0] dat_r_r;
   logic resp_valid_r;
   chk_resp_s resp_r;
   chk_resp_s resp_nxt;
   eff_s eff_r;
   eff_s eff_nxt;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // writes land on the edge where the master sees ack, not one earlier
   wire acc = cyc & stb & ~ack_r;
   wire wr = cyc & stb & we & ack_r;
   wire hit_lo = adr == `CFG_LO_OFS;
   wire hit_hi = adr == `CFG_HI_OFS;
   wire hit_stat = adr == `IRQ_STAT_OFS;
   wire hit_mask = adr == `IRQ_MASK_OFS;
   wire hit_eff = adr == `EFF_STAT_OFS;

   genvar k;
   generate
      for (k = 0; k < 8; k++) begin : g_lane
         wire lane_hit = wr & ((k < 4) ? hit_lo : hit_hi) & sel[k % 4];
         wire [7:0] wm = CFG_WMASK[8*k +: 8];
         assign cfg_nxt[8*k +: 8] = lane_hit ? ((dat_w[8*(k % 4) +: 8] & wm) | (cfg_r[8*k +: 8] & ~wm))
                                             : cfg_r[8*k +: 8];
      end
   endgenerate

   wire [31:0] rd_lo = cfg_r[31:0] | (32'h1 << `BIT_RAO);
   wire [31:0] rd_hi = cfg_r[63:32];
   // unmapped offsets read zero and still acknowledge
   wire [31:0] rd_mux = hit_lo ? rd_lo :
                        hit_hi ? rd_hi :
                        hit_stat ? {27'h000_0000, stat_r} :
                        hit_mask ? {27'h000_0000, mask_r} :
                        hit_eff ? {28'h000_0000, eff_r} : 32'h0000_0000;

   // ------------------------------------------------------------
   // field values as the hardware sees them
   // ------------------------------------------------------------
   wire f_mismatch = cfg_r[`BIT_MISMATCH];
   wire f_abort = cfg_r[`BIT_ABORT_ROUTE];
   wire f_err = cfg_r[`BIT_ERR_TRAP];
   wire f_lor = cfg_r[`BIT_LOR_TRAP];
   wire f_host = cfg_r[`BIT_HOST];
   wire f_inst_nc = cfg_r[`BIT_S2_INST_NC];
   wire f_data_nc = cfg_r[`BIT_S2_DATA_NC];
   wire f_memctl = cfg_r[`BIT_MEMCTL_RD];
   wire f_hvc_dis = cfg_r[`BIT_HVC_DIS];
   wire f_tge = cfg_r[`BIT_TRAP_GEN];
   wire f_s2 = cfg_r[`BIT_S2_EN];

   // readback stays raw; only the effect is suppressed
   wire host_tge = HAS_VHE & f_host & f_tge;
   wire e_mismatch = f_mismatch & ~host_tge;
   wire e_inst_nc = f_inst_nc & ~host_tge;
   wire e_data_nc = f_data_nc & ~host_tge;
   wire e_lor = f_lor & ~f_tge;
   wire e_memctl = f_memctl & ~f_tge;

   // only stage 2 of the EL1&0 regime is ever forced non-cacheable
   wire s2_live = el2_enabled & f_s2 & (regime == REGIME_EL10);
   assign eff_nxt.coherent_required = ~e_mismatch;
   assign eff_nxt.s2_inst_nc = e_inst_nc & s2_live;
   assign eff_nxt.s2_data_nc = e_data_nc & s2_live;
   assign eff_nxt.host_at_hyp = f_host;

   // ------------------------------------------------------------
   // trap decode
   // ------------------------------------------------------------
   wire at_el1 = chk_req.el == `EL_1;
   wire [5:0] ec_coproc = chk_req.double_reg ? `EC_COPROC_DOUBLE : `EC_COPROC_SINGLE;
   wire [5:0] ec_sysreg = chk_req.aarch32 ? ec_coproc : `EC_SYSREG64;

   wire k_err = chk_req.kind == KIND_ERR_REC;
   wire k_lor = chk_req.kind == KIND_LOR_REG;
   wire k_mem = chk_req.kind == KIND_MEMCTL_RD;
   wire k_hvc = chk_req.kind == KIND_HVC;
   wire k_abt = chk_req.kind == KIND_SYNC_ABORT;

   wire t_err = k_err & f_err & el2_enabled & at_el1;
   wire t_lor = k_lor & e_lor & at_el1 & chk_req.nonsecure;
   wire t_mem = k_mem & e_memctl & el2_enabled & at_el1;
   wire hvc_el0 = k_hvc & (chk_req.el == `EL_0);
   wire hvc_off = k_hvc & ~HAS_EL3 & f_hvc_dis & (at_el1 | (chk_req.el == `EL_2));
   wire r_abt = k_abt & f_abort & el2_enabled & ~chk_req.abort_to_el3 &
                (chk_req.el == `EL_0 | at_el1);
   wire hvc_undef = hvc_el0 | hvc_off;

   always_comb begin
      resp_nxt = '0;
      resp_nxt.target_el = chk_req.el;
      resp_nxt.syndrome = `EC_UNKNOWN;
      if (t_err | t_lor | t_mem) begin
         resp_nxt.trap_el2 = 1'b1;
         resp_nxt.target_el = `EL_2;
         resp_nxt.syndrome = t_lor ? `EC_SYSREG64 : ec_sysreg;
      end else if (hvc_undef) begin
         resp_nxt.undef = 1'b1;
         // undefined at EL0 is taken at EL1; otherwise at the executing level
         resp_nxt.target_el = hvc_el0 ? `EL_1 : chk_req.el;
         resp_nxt.syndrome = `EC_UNKNOWN;
      end else if (r_abt) begin
         resp_nxt.route_el2 = 1'b1;
         resp_nxt.target_el = `EL_2;
      end
   end

   // ------------------------------------------------------------
   // interrupt status: set beats a same-cycle clear
   // ------------------------------------------------------------
   wire [`IRQ_W-1:0] ev;
   assign ev[`IRQ_ERR] = chk_valid & t_err;
   assign ev[`IRQ_LOR] = chk_valid & t_lor;
   assign ev[`IRQ_MEMCTL] = chk_valid & t_mem;
   assign ev[`IRQ_HVC_UNDEF] = chk_valid & hvc_undef;
   assign ev[`IRQ_ABORT] = chk_valid & r_abt;
   wire [`IRQ_W-1:0] w1c = (wr & hit_stat & sel[0]) ? dat_w[`IRQ_W-1:0] : `IRQ_RESET;
   assign stat_nxt = (stat_r & ~w1c) | ev;
   assign mask_nxt = (wr & hit_mask & sel[0]) ? dat_w[`IRQ_W-1:0] : mask_r;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // reset picks zero: software must not rely on it, but simulation stays defined
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg_r <= `CFG_RESET;
         stat_r <= `IRQ_RESET;
         mask_r <= `IRQ_RESET;
      end else begin
         cfg_r <= cfg_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_r <= 1'b0;
         dat_r_r <= 32'h0000_0000;
      end else begin
         ack_r <= acc;
         dat_r_r <= acc ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         resp_valid_r <= 1'b0;
         resp_r <= '0;
         eff_r <= '0;
      end else begin
         resp_valid_r <= chk_valid;
         resp_r <= chk_valid ? resp_nxt : '0;
         eff_r <= eff_nxt;
      end
   end

   assign ack = ack_r;
   assign dat_r = dat_r_r;
   assign resp_valid = resp_valid_r;
   assign resp = resp_r;
   assign eff = eff_r;
   assign irq = |(stat_r & mask_r);

endmodule

`default_nettype wire

// file: test/hyp_trap_route_controls_assertions.sv
// port-level property checks for the hypervisor trap block
`timescale 1ns/1ns
`default_nettype none
`include "hyp_trap_defs.svh"

module hyp_trap_route_controls_assertions
   import hyp_trap_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register bus
   input wire logic cyc,
   input wire logic stb,
   input wire logic [31:0] dat_r,
   input wire logic ack,
   // context, trap check, controls
   input wire logic el2_enabled,
   input wire regime_e regime,
   input wire logic chk_valid,
   input wire chk_req_s chk_req,
   input wire logic resp_valid,
   input wire chk_resp_s resp,
   input wire eff_s eff
);
   // ----------
   // shared pieces
   // ----------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_hvc_el0;
      chk_valid && chk_req.kind == KIND_HVC && chk_req.el == `EL_0;
   endsequence
   sequence s_undef_el1;
      resp.undef && resp.target_el == `EL_1 && resp.syndrome == `EC_UNKNOWN;
   endsequence
   // syndrome depends on state and register width of the trapped access
   property p_sys_trap(kind_e k);
      resp_valid && resp.trap_el2 && $past(chk_req.kind) == k |-> resp.target_el == `EL_2 && $past(el2_enabled) &&
         resp.syndrome == ($past(chk_req.aarch32) ?
         ($past(chk_req.double_reg) ? `EC_COPROC_DOUBLE : `EC_COPROC_SINGLE) : `EC_SYSREG64);
   endproperty

   // ----------
   // checks
   // ----------
   a_resp_latency: assert property (resp_valid == $past(chk_valid))
      else $error("trap answer not one cycle after request");
   a_hvc_el0_undef: assert property (s_hvc_el0 |=> s_undef_el1)
      else $error("hvc at el0 not undefined at el1");
   a_err_syndrome: assert property (p_sys_trap(KIND_ERR_REC))
      else $error("error record trap wrong");
   a_memctl_syndrome: assert property (p_sys_trap(KIND_MEMCTL_RD))
      else $error("memory control read trap wrong");
   a_trap_el2_gate: assert property (chk_valid && !el2_enabled && chk_req.kind inside {KIND_ERR_REC, KIND_MEMCTL_RD}
      |=> !resp.trap_el2) else $error("trap taken with el2 disabled");
   a_lor_scope: assert property (resp.trap_el2 && $past(chk_req.kind) == KIND_LOR_REG
      |-> $past(chk_req.nonsecure) && $past(chk_req.el) == `EL_1) else $error("ordering trap out of scope");
   a_abort_route: assert property (resp.route_el2 |-> resp.target_el == `EL_2 && !$past(chk_req.abort_to_el3)
      && $past(el2_enabled)) else $error("abort routing wrong");
   a_s2_regime: assert property (eff.s2_inst_nc || eff.s2_data_nc |-> $past(regime) == REGIME_EL10
      && $past(el2_enabled)) else $error("no-cache outside guest regime");
   a_ack_pulse: assert property (cyc && stb && !ack |=> ack ##1 !ack)
      else $error("bus answer not a one-cycle pulse");
   a_read_idle: assert property (!ack |-> dat_r == '0)
      else $error("read data not zero while idle");
endmodule

`default_nettype wire

// file: test/test_hyp_trap_route_controls.sv
// self-checking bench for the hypervisor trap block
`timescale 1ns/1ns
`default_nettype none
`include "hyp_trap_defs.svh"

module test_hyp_trap_route_controls import hyp_trap_pkg::*;;
   logic clk_sys, rst, cyc, stb, we, ack, el2_enabled, chk_valid, resp_valid, irq;
   logic [7:0] adr;
   logic [31:0] dat_w, dat_r, q;
   regime_e regime;
   chk_req_s chk_req;
   chk_resp_s resp;
   eff_s eff;
   int err_total, check_count, cycles;

   hyp_trap_route_controls u_hyp_trap_route_controls (.clk_sys(clk_sys), .rst(rst), .cyc(cyc), .stb(stb), .we(we),
      .adr(adr), .sel(4'hF), .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .el2_enabled(el2_enabled), .regime(regime),
      .chk_valid(chk_valid), .chk_req(chk_req), .resp_valid(resp_valid), .resp(resp), .eff(eff), .irq(irq));

   task automatic results;
      if (err_total == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ----------
   // wishbone classic single cycle
   // ----------
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      // one edge takes the request, the next one sees ack
      cmp(32'(n), 32'h0000_0002);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      cmp(q, exp);
   endtask

   // f = {aarch32, double, nonsecure, abort_to_el3}; act = {trap, undef, route, target el}
   task automatic chk(input kind_e k, input logic [1:0] el, input logic [3:0] f, input logic e2, input logic [4:0] act,
      input logic [5:0] syn);
      @(posedge clk_sys);
      chk_valid <= 1'b1;
      chk_req <= '{k, el, f[3], f[2], f[1], f[0]};
      el2_enabled <= e2;
      @(posedge clk_sys);
      chk_valid <= 1'b0;
      #1;
      cmp({20'h0_0000, resp_valid, resp}, {20'h0_0000, 1'b1, act, syn});
   endtask

   task automatic eff_is(input regime_e r, input logic [3:0] e);
      @(posedge clk_sys);
      regime <= r;
      repeat (2) @(posedge clk_sys);
      #1;
      cmp({28'h000_0000, eff}, {28'h000_0000, e});
   endtask

   // ----------
   // clock, timeout, sequence
   // ----------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         cmp(32'h0000_0001, 32'h0000_0000);
         results();
      end
   end

   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      dat_w = 32'h0000_0000;
      el2_enabled = 1'b1;
      regime = REGIME_EL10;
      chk_valid = 1'b0;
      chk_req = '0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      rd(`CFG_LO_OFS, 32'h8000_0000);
      rd(`CFG_HI_OFS, 32'h0000_0000);
      rd(`EFF_STAT_OFS, 32'h0000_0008);
      wb(1'b1, 8'h20, 32'hFFFF_FFFF);
      rd(8'h20, 32'h0000_0000);
      wb(1'b1, `CFG_HI_OFS, 32'h0000_007F);
      wb(1'b1, `CFG_LO_OFS, 32'h6000_0001);
      rd(`CFG_HI_OFS, 32'h0000_007F);
      rd(`CFG_LO_OFS, 32'hE000_0001);
      eff_is(REGIME_EL10, 4'h7);
      chk(KIND_ERR_REC, `EL_1, 4'h2, 1'b1, 5'h12, `EC_SYSREG64);
      chk(KIND_ERR_REC, `EL_1, 4'hA, 1'b1, 5'h12, `EC_COPROC_SINGLE);
      chk(KIND_ERR_REC, `EL_1, 4'hE, 1'b1, 5'h12, `EC_COPROC_DOUBLE);
      chk(KIND_ERR_REC, `EL_1, 4'h2, 1'b0, 5'h01, `EC_UNKNOWN);
      chk(KIND_LOR_REG, `EL_1, 4'h2, 1'b1, 5'h12, `EC_SYSREG64);
      chk(KIND_LOR_REG, `EL_1, 4'h0, 1'b1, 5'h01, `EC_UNKNOWN);
      chk(KIND_MEMCTL_RD, `EL_1, 4'h2, 1'b1, 5'h12, `EC_SYSREG64);
      chk(KIND_MEMCTL_RD, `EL_1, 4'hE, 1'b1, 5'h12, `EC_COPROC_DOUBLE);
      chk(KIND_HVC, `EL_0, 4'h0, 1'b1, 5'h09, `EC_UNKNOWN);
      chk(KIND_HVC, `EL_1, 4'h0, 1'b1, 5'h09, `EC_UNKNOWN);
      chk(KIND_HVC, `EL_2, 4'h0, 1'b1, 5'h0A, `EC_UNKNOWN);
      chk(KIND_SYNC_ABORT, `EL_0, 4'h0, 1'b1, 5'h06, `EC_UNKNOWN);
      chk(KIND_SYNC_ABORT, `EL_0, 4'h1, 1'b1, 5'h00, `EC_UNKNOWN);
      cmp({31'h0, irq}, 32'h0000_0000);
      rd(`IRQ_STAT_OFS, 32'h0000_001F);
      wb(1'b1, `IRQ_MASK_OFS, 32'h0000_0004);
      #1;
      cmp({31'h0, irq}, 32'h0000_0001);
      wb(1'b1, `IRQ_STAT_OFS, 32'h0000_0004);
      #1;
      cmp({31'h0, irq}, 32'h0000_0000);
      rd(`IRQ_STAT_OFS, 32'h0000_001B);
      eff_is(REGIME_EL2, 4'h1);
      wb(1'b1, `CFG_LO_OFS, 32'h6800_0001);
      eff_is(REGIME_EL10, 4'h9);
      chk(KIND_LOR_REG, `EL_1, 4'h2, 1'b1, 5'h01, `EC_UNKNOWN);
      chk(KIND_MEMCTL_RD, `EL_1, 4'h2, 1'b1, 5'h01, `EC_UNKNOWN);
      wb(1'b1, `CFG_LO_OFS, 32'h4000_0001);
      chk(KIND_HVC, `EL_1, 4'h0, 1'b1, 5'h01, `EC_UNKNOWN);
      chk(KIND_HVC, `EL_0, 4'h0, 1'b1, 5'h09, `EC_UNKNOWN);
      // warm reset in mid-run must clear the stored fields again
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(`CFG_HI_OFS, 32'h0000_0000);
      rd(`CFG_LO_OFS, 32'h8000_0000);
      rd(`IRQ_STAT_OFS, 32'h0000_0000);
      results();
   end
endmodule

bind hyp_trap_route_controls hyp_trap_route_controls_assertions u_hyp_trap_route_controls_assertions (
   .clk_sys(clk_sys), .rst(rst), .cyc(cyc), .stb(stb), .dat_r(dat_r), .ack(ack), .el2_enabled(el2_enabled),
   .regime(regime), .chk_valid(chk_valid), .chk_req(chk_req), .resp_valid(resp_valid), .resp(resp), .eff(eff));

`default_nettype wire
